// [shared/fsc_pkg.sv]
// Shared constants for the file-store command and status link
// Notes on behaviour
// [RULE1] Busy held high until start-up init done
// [RULE2] Command codes: 00 format, 10 write, 11 read, 01 shutdown
// [RULE3] Accepted command raises busy from zero
// [RULE4] Busy clears when command fully completes
// [RULE5] Error flag is status bit 1
// [RULE6] Read mismatch sets status bit 2
// [RULE7] Mismatch never aborts; host keeps polling
// [RULE8] Host abandons command when error rises
// [RULE9] Host loads timestamp and size before format
// [RULE10] Host reads capacity pair before format; fsc_host never reads disk_capacity_low or disk_capacity_high
// [RULE11] Format reports capacity, per-directory, size, total
// [RULE12] Host loads start, count, pattern before transfer
// [RULE13] Timestamp written only before write commands; the host also writes it before format
// [RULE14] Write start continues after previous write
// [RULE15] Running byte count readable during transfer
// [RULE16] Running count split high and low words
// [RULE17] Shutdown success makes device inactive forever
// [RULE18] Unformatted start loads defaults, reads disk info; fsc_host never reads the disk information outputs
// [RULE19] Host computes time, bytes and throughput; fsc_host records o_elapsed and o_bytes but no throughput
// [RULE20] Command writes while busy are ignored
package fsc_pkg;
	localparam int CMD_W = 2;
	localparam logic [1:0] CMD_FORMAT = 2'h0;
	localparam logic [1:0] CMD_SHUTDOWN = 2'h1;
	localparam logic [1:0] CMD_WRITE = 2'h2;
	localparam logic [1:0] CMD_READ = 2'h3;
	localparam int STS_BUSY = 0;
	localparam int STS_ERR = 1;
	localparam int STS_VERR = 2;
	localparam logic [2:0] STS_RESET = 3'h1;
	localparam int INIT_CYCLES = 16;
	localparam int FORMAT_CYCLES = 32;
	localparam int SHUTDOWN_CYCLES = 8;
	localparam int BYTES_PER_BEAT = 16;
	localparam int FILE_BYTES_LOG2 = 8;
	localparam logic [2:0] DEF_FILE_SIZE = 3'h0;
	localparam logic [26:0] DEF_FILE_CAP = 27'h0001000;
	localparam logic [19:0] DEF_DIR_CAP = 20'h00400;
	localparam logic [31:0] DEF_TIMESTAMP = 32'h0;
	localparam logic [2:0] DEF_PATTERN = 3'h0;
	localparam logic [31:0] DEF_CAP_LOW = 32'h00100000;
	localparam logic [15:0] DEF_CAP_HIGH = 16'h0;
	localparam logic [26:0] DEF_FILE_COUNT = 27'h1;
endpackage

// [shared/fsc_link_if.sv]
// Interface joining the host firmware end and the device command end
`timescale 1ns/1ps
interface fsc_link_if;
	logic cmd_valid;
	logic [1:0] user_command_code;
	logic [31:0] creation_timestamp;
	logic [2:0] requested_file_size;
	logic [26:0] start_file_number;
	logic [26:0] file_count_request;
	logic [2:0] test_pattern_select;
	logic [2:0] user_status_word;
	logic [31:0] disk_capacity_low;
	logic [15:0] disk_capacity_high;
	logic [2:0] disk_file_size;
	logic [26:0] disk_file_total;
	logic [26:0] max_file_capacity;
	logic [19:0] files_per_directory_max;
	logic [31:0] running_count_low;
	logic [24:0] running_count_high;
	logic inactive;
	modport device (
		input cmd_valid, user_command_code, creation_timestamp, requested_file_size,
		start_file_number, file_count_request, test_pattern_select,
		output user_status_word, disk_capacity_low, disk_capacity_high, disk_file_size,
		disk_file_total, max_file_capacity, files_per_directory_max,
		running_count_low, running_count_high, inactive
	);
	modport host (
		output cmd_valid, user_command_code, creation_timestamp, requested_file_size,
		start_file_number, file_count_request, test_pattern_select,
		input user_status_word, disk_capacity_low, disk_capacity_high, disk_file_size,
		disk_file_total, max_file_capacity, files_per_directory_max,
		running_count_low, running_count_high, inactive
	);
endinterface

// [design/fsc_device.sv]
// Device end: command interpreter, status word and disk information of the file store
`timescale 1ns/1ps
module fsc_device #(
	parameter int INIT_CYCLES = fsc_pkg::INIT_CYCLES,
	parameter int FORMAT_CYCLES = fsc_pkg::FORMAT_CYCLES,
	parameter int SHUTDOWN_CYCLES = fsc_pkg::SHUTDOWN_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ce,
	fsc_link_if.device link,
	input wire logic i_beat_valid,
	input wire logic i_beat_mismatch,
	input wire logic i_disk_error,
	output logic o_active_cmd_valid,
	output logic [1:0] o_active_cmd
);
	typedef enum logic [4:0] {
		FSC_INIT = 5'h01,
		FSC_IDLE = 5'h02,
		FSC_RUN = 5'h04,
		FSC_DONE = 5'h08,
		FSC_OFF = 5'h10
	} fsc_state_t;

	fsc_state_t state;
	logic [31:0] timer;
	logic [26:0] files_left;
	logic [fsc_pkg::FILE_BYTES_LOG2-1:0] beat_in_file;
	logic [56:0] byte_count;
	logic [1:0] cmd;
	logic err;
	logic verr;
	logic [2:0] file_size;
	logic [26:0] file_total;
	logic [26:0] file_cap;
	logic [19:0] dir_cap;
	logic is_xfer;
	logic last_beat;

	// [RULE2] command code decode
	function automatic logic is_transfer(input logic [1:0] c);
		return c == fsc_pkg::CMD_WRITE || c == fsc_pkg::CMD_READ;
	endfunction

	assign is_xfer = is_transfer(cmd);
	assign last_beat = (&beat_in_file) && files_left == 27'h1;

	// Sequencer
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state <= FSC_INIT;
			timer <= 32'h0;
			cmd <= fsc_pkg::CMD_FORMAT;
		end else if (i_ce) begin
			case (state)
				// [RULE1] busy during init
				FSC_INIT: begin
					timer <= timer + 32'h1;
					if (timer == 32'(INIT_CYCLES - 1)) begin
						state <= FSC_IDLE;
					end
				end
				FSC_IDLE: begin
					// [RULE20] accept only when idle
					if (link.cmd_valid) begin
						cmd <= link.user_command_code;
						timer <= 32'h0;
						state <= FSC_RUN;
					end
				end
				FSC_RUN: begin
					timer <= timer + 32'h1;
					// [RULE7] mismatch does not stop
					if (i_disk_error) begin
						state <= FSC_DONE;
					end else if (is_xfer) begin
						if (files_left == 27'h0 || (i_beat_valid && last_beat)) begin
							state <= FSC_DONE;
						end
					end else if (cmd == fsc_pkg::CMD_FORMAT && timer == 32'(FORMAT_CYCLES - 1)) begin
						state <= FSC_DONE;
					end else if (cmd == fsc_pkg::CMD_SHUTDOWN && timer == 32'(SHUTDOWN_CYCLES - 1)) begin
						state <= FSC_DONE;
					end
				end
				FSC_DONE: begin
					// [RULE17] shutdown success goes inactive
					if (cmd == fsc_pkg::CMD_SHUTDOWN && !err) begin
						state <= FSC_OFF;
					end else begin
						state <= FSC_IDLE;
					end
				end
				FSC_OFF: begin
					state <= FSC_OFF;
				end
				default: begin
					state <= FSC_INIT;
				end
			endcase
		end
	end

	// File and beat progress
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			files_left <= 27'h0;
			beat_in_file <= '0;
		end else if (i_ce) begin
			if (state == FSC_IDLE && link.cmd_valid) begin
				files_left <= link.file_count_request;
				beat_in_file <= '0;
			end else if (state == FSC_RUN && is_xfer && i_beat_valid && files_left != 27'h0) begin
				beat_in_file <= beat_in_file + 1'b1;
				if (&beat_in_file) begin
					files_left <= files_left - 27'h1;
				end
			end
		end
	end

	// Running byte count
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			byte_count <= 57'h0;
		end else if (i_ce) begin
			if (state == FSC_IDLE && link.cmd_valid && is_transfer(link.user_command_code)) begin
				byte_count <= 57'h0;
			// [RULE15] count bytes while transferring
			end else if (state == FSC_RUN && is_xfer && i_beat_valid && files_left != 27'h0) begin
				byte_count <= byte_count + 57'(fsc_pkg::BYTES_PER_BEAT);
			end
		end
	end

	// Error and verification flags
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			err <= 1'b0;
			verr <= 1'b0;
		end else if (i_ce) begin
			if (state == FSC_IDLE && link.cmd_valid) begin
				err <= 1'b0;
				verr <= 1'b0;
			end else if (state == FSC_RUN || state == FSC_INIT) begin
				// [RULE5] error sets bit 1
				if (i_disk_error) begin
					err <= 1'b1;
				end
				// [RULE6] read mismatch sets bit 2
				if (cmd == fsc_pkg::CMD_READ && state == FSC_RUN && i_beat_valid && i_beat_mismatch) begin
					verr <= 1'b1;
				end
			end
		end
	end

	// Disk information
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			file_size <= fsc_pkg::DEF_FILE_SIZE;
			file_total <= 27'h0;
			file_cap <= fsc_pkg::DEF_FILE_CAP;
			dir_cap <= fsc_pkg::DEF_DIR_CAP;
		end else if (i_ce) begin
			if (state == FSC_IDLE && link.cmd_valid && link.user_command_code == fsc_pkg::CMD_FORMAT) begin
				file_size <= link.requested_file_size;
			// [RULE11] format results reported
			end else if (state == FSC_DONE && cmd == fsc_pkg::CMD_FORMAT && !err) begin
				file_total <= 27'h0;
				file_cap <= 27'(fsc_pkg::DEF_FILE_CAP >> file_size);
				dir_cap <= fsc_pkg::DEF_DIR_CAP;
			end else if (state == FSC_DONE && cmd == fsc_pkg::CMD_WRITE) begin
				file_total <= file_total + (link.file_count_request - files_left);
			end
		end
	end

	// Registered outputs toward the host
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			link.user_status_word <= fsc_pkg::STS_RESET;
			link.disk_file_size <= fsc_pkg::DEF_FILE_SIZE;
			link.disk_file_total <= 27'h0;
			link.max_file_capacity <= fsc_pkg::DEF_FILE_CAP;
			link.files_per_directory_max <= fsc_pkg::DEF_DIR_CAP;
			link.disk_capacity_low <= fsc_pkg::DEF_CAP_LOW;
			link.disk_capacity_high <= fsc_pkg::DEF_CAP_HIGH;
			link.running_count_low <= 32'h0;
			link.running_count_high <= 25'h0;
			link.inactive <= 1'b0;
			o_active_cmd_valid <= 1'b0;
			o_active_cmd <= 2'h0;
		end else if (i_ce) begin
			// [RULE3] busy rises on accepted command
			// [RULE4] busy clears at completion
			// Busy also covers the done cycle, so results settle no later than busy falls
			link.user_status_word[fsc_pkg::STS_BUSY] <= (state == FSC_INIT || state == FSC_RUN) ||
				(state == FSC_DONE) || (state == FSC_IDLE && link.cmd_valid);
			link.user_status_word[fsc_pkg::STS_ERR] <= err;
			link.user_status_word[fsc_pkg::STS_VERR] <= verr;
			link.disk_file_size <= file_size;
			link.disk_file_total <= file_total;
			link.max_file_capacity <= file_cap;
			link.files_per_directory_max <= dir_cap;
			// [RULE16] count split into two words
			link.running_count_low <= byte_count[31:0];
			link.running_count_high <= byte_count[56:32];
			link.inactive <= (state == FSC_OFF);
			o_active_cmd_valid <= (state == FSC_RUN);
			o_active_cmd <= cmd;
		end
	end
endmodule

// [design/fsc_host.sv]
// Host end: firmware-like sequencer that loads parameters, issues commands and polls status
`timescale 1ns/1ps
module fsc_host (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ce,
	fsc_link_if.host link,
	input wire logic i_req,
	input wire logic [1:0] i_req_cmd,
	input wire logic [31:0] i_timestamp,
	input wire logic [2:0] i_file_size,
	input wire logic [26:0] i_start_file,
	input wire logic i_start_file_valid,
	input wire logic [26:0] i_file_count,
	input wire logic [2:0] i_pattern,
	input wire logic i_cancel,
	output logic o_ready,
	output logic o_done,
	output logic o_error,
	output logic o_verify_error,
	output logic [31:0] o_elapsed,
	output logic [56:0] o_bytes
);
	typedef enum logic [4:0] {
		FSH_BOOT = 5'h01,
		FSH_IDLE = 5'h02,
		FSH_ISSUE = 5'h04,
		FSH_WAIT = 5'h08,
		FSH_OFF = 5'h10
	} fsh_state_t;

	fsh_state_t state;
	logic [26:0] next_write_start;
	logic [31:0] timer;
	logic [1:0] cmd;
	logic booted;
	logic busy;

	// Status comes from logic on this clock, so it is read directly
	assign busy = link.user_status_word[fsc_pkg::STS_BUSY];

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state <= FSH_BOOT;
			booted <= 1'b0;
			cmd <= fsc_pkg::CMD_FORMAT;
			timer <= 32'h0;
			next_write_start <= 27'h0;
			link.cmd_valid <= 1'b0;
			link.user_command_code <= 2'h0;
			link.creation_timestamp <= fsc_pkg::DEF_TIMESTAMP;
			link.requested_file_size <= fsc_pkg::DEF_FILE_SIZE;
			link.start_file_number <= 27'h0;
			link.file_count_request <= fsc_pkg::DEF_FILE_COUNT;
			link.test_pattern_select <= fsc_pkg::DEF_PATTERN;
			o_ready <= 1'b0;
			o_done <= 1'b0;
			o_error <= 1'b0;
			o_verify_error <= 1'b0;
			o_elapsed <= 32'h0;
			o_bytes <= 57'h0;
		end else if (i_ce) begin
			link.cmd_valid <= 1'b0;
			o_done <= 1'b0;
			timer <= timer + 32'h1;
			case (state)
				FSH_BOOT: begin
					// [RULE1] wait for init to finish
					// [RULE18] defaults already loaded from reset
					if (!busy && booted) begin
						state <= FSH_IDLE;
						o_ready <= 1'b1;
					end
					booted <= 1'b1;
				end
				FSH_IDLE: begin
					if (i_req) begin
						cmd <= i_req_cmd;
						// [RULE9] [RULE10] format parameters first
						if (i_req_cmd == fsc_pkg::CMD_FORMAT) begin
							link.creation_timestamp <= i_timestamp;
							link.requested_file_size <= i_file_size;
						end
						// [RULE12] [RULE13] [RULE14] transfer parameters first
						if (i_req_cmd == fsc_pkg::CMD_WRITE) begin
							link.creation_timestamp <= i_timestamp;
							link.start_file_number <= i_start_file_valid ? i_start_file : next_write_start;
						end else if (i_req_cmd == fsc_pkg::CMD_READ) begin
							link.start_file_number <= i_start_file;
						end
						link.file_count_request <= i_file_count;
						link.test_pattern_select <= i_pattern;
						o_ready <= 1'b0;
						state <= FSH_ISSUE;
					end
				end
				FSH_ISSUE: begin
					// [RULE2] [RULE20] one command while idle
					link.user_command_code <= cmd;
					link.cmd_valid <= 1'b1;
					o_error <= 1'b0;
					o_verify_error <= 1'b0;
					timer <= 32'h0;
					state <= FSH_WAIT;
				end
				FSH_WAIT: begin
					o_verify_error <= link.user_status_word[fsc_pkg::STS_VERR];
					o_bytes <= {link.running_count_high, link.running_count_low};
					// [RULE8] error abandons the command
					if (timer > 32'h4 && (link.user_status_word[fsc_pkg::STS_ERR] || i_cancel)) begin
						o_error <= link.user_status_word[fsc_pkg::STS_ERR];
						o_done <= 1'b1;
						o_ready <= 1'b1;
						state <= FSH_IDLE;
					// [RULE7] [RULE19] finish on busy low, record results
					end else if (timer > 32'h4 && !busy) begin
						o_elapsed <= timer;
						o_done <= 1'b1;
						if (cmd == fsc_pkg::CMD_WRITE) begin
							next_write_start <= link.start_file_number + link.file_count_request;
						end
						// [RULE17] no commands after shutdown
						if (cmd == fsc_pkg::CMD_SHUTDOWN) begin
							state <= FSH_OFF;
						end else begin
							o_ready <= 1'b1;
							state <= FSH_IDLE;
						end
					end
				end
				FSH_OFF: begin
					state <= FSH_OFF;
				end
				default: begin
					state <= FSH_BOOT;
				end
			endcase
		end
	end
endmodule

// [tb/fsc_link_properties.sv]
// Concurrent checks on the command and status link between host and device
`timescale 1ns/1ps
module fsc_link_properties (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic cmd_valid,
	input wire logic [1:0] user_command_code,
	input wire logic [2:0] user_status_word,
	input wire logic [2:0] disk_file_size,
	input wire logic [26:0] disk_file_total,
	input wire logic [26:0] max_file_capacity,
	input wire logic [31:0] running_count_low,
	input wire logic [24:0] running_count_high,
	input wire logic inactive
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	logic busy;
	logic take;
	logic last_fmt;
	logic [56:0] cnt;
	assign busy = user_status_word[0];
	assign take = cmd_valid && !busy && !inactive;
	assign cnt = {running_count_high, running_count_low};
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			last_fmt <= 1'b0;
		end else if (take) begin
			last_fmt <= (user_command_code == fsc_pkg::CMD_FORMAT);
		end
	end
	sequence s_fmt_go;
		take && user_command_code == fsc_pkg::CMD_FORMAT;
	endsequence
	sequence s_shut_go;
		take && user_command_code == fsc_pkg::CMD_SHUTDOWN;
	endsequence
	sequence s_fmt_run;
		busy [*8] ##[20:40] !busy;
	endsequence
	sequence s_shut_run;
		busy [*4] ##[1:12] (!busy && (inactive || user_status_word[1]));
	endsequence
	AST_INIT_BUSY: assert property ($fell(i_rst) |-> busy [*8])
		else $error("busy not held after reset");
	AST_TAKE_BUSY: assert property (take |=> busy)
		else $error("accepted command did not raise busy");
	AST_FMT_RUN: assert property (s_fmt_go |=> s_fmt_run)
		else $error("format run length wrong");
	AST_FMT_INFO: assert property ($fell(busy) && last_fmt && !user_status_word[1]
		|-> disk_file_total == 27'h0 && max_file_capacity == (fsc_pkg::DEF_FILE_CAP >> disk_file_size))
		else $error("format results wrong");
	AST_ERR_END: assert property ($rose(user_status_word[1]) |-> ##[0:3] !busy)
		else $error("error did not end command");
	AST_VERR_RUN: assert property ($rose(user_status_word[2]) |-> busy)
		else $error("mismatch stopped command");
	AST_FLAG_HOLD: assert property (!busy && !$past(busy) |-> $stable(user_status_word[2:1]))
		else $error("flags changed while idle");
	AST_CNT_STEP: assert property (busy && $past(busy)
		|-> cnt == 57'h0 || (cnt - $past(cnt)) inside {57'h0, 57'h10})
		else $error("running count step wrong");
	AST_OFF_STAY: assert property (inactive |=> inactive)
		else $error("inactive state left");
	AST_OFF_DEAF: assert property (inactive && cmd_valid |=> !busy [*3])
		else $error("command taken while inactive");
	AST_SHUT_RUN: assert property (s_shut_go |=> s_shut_run)
		else $error("shutdown sequence wrong");
endmodule

// [tb/file_store_cmd_status_tb_top.sv]
// Testbench: host and device joined over the link, plus a lone device driven directly
`timescale 1ns/1ps
module file_store_cmd_status_tb_top;
	logic clk, rst, ce, req, rdy, done, err_h, verr_h, act, act2, bv, bm, de, mis_on, err_on;
	logic [1:0] req_cmd, acmd;
	logic [2:0] fsize;
	logic [26:0] fcount;
	logic [31:0] elapsed;
	logic [31:0] cyc = 32'h0;
	logic [56:0] bytes;
	logic [9:0] bn;
	int n_fail, n_checks;
	fsc_link_if lnk ();
	fsc_link_if lnk2 ();
	fsc_device fsc_device_inst (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .link(lnk.device), .i_beat_valid(bv),
		.i_beat_mismatch(bm), .i_disk_error(de), .o_active_cmd_valid(act), .o_active_cmd(acmd));
	fsc_device fsc_device_inst_b (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .link(lnk2.device), .i_beat_valid(bv),
		.i_beat_mismatch(bm), .i_disk_error(de), .o_active_cmd_valid(act2), .o_active_cmd());
	fsc_host fsc_host_inst (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .link(lnk.host), .i_req(req),
		.i_req_cmd(req_cmd), .i_timestamp(cyc), .i_file_size(fsize), .i_start_file(27'h0),
		.i_start_file_valid(1'b0), .i_file_count(fcount), .i_pattern(fsize), .i_cancel(1'b0), .o_ready(rdy),
		.o_done(done), .o_error(err_h), .o_verify_error(verr_h), .o_elapsed(elapsed), .o_bytes(bytes));
	fsc_link_properties fsc_link_properties_inst (.i_clk_sys(clk), .i_rst(rst), .cmd_valid(lnk.cmd_valid),
		.user_command_code(lnk.user_command_code), .user_status_word(lnk.user_status_word),
		.disk_file_size(lnk.disk_file_size), .disk_file_total(lnk.disk_file_total),
		.max_file_capacity(lnk.max_file_capacity), .running_count_low(lnk.running_count_low),
		.running_count_high(lnk.running_count_high), .inactive(lnk.inactive));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic end_sim;
		if (n_fail == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 32'h1;
		if (cyc == 32'h1770) begin
			n_fail++;
			end_sim;
		end
	end
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Disk side: one beat per cycle for transfers, optional mismatch or fault
	always begin
		tick;
		bv = act && acmd[1];
		bm = act && acmd[1] && mis_on && bn == 10'h00a;
		de = act && err_on && bn == 10'h005;
		bn = act ? bn + 10'h1 : 10'h0;
	end
	task automatic run(input logic [1:0] c, input logic [26:0] n);
		int k;
		logic [1:0] seen;
		k = 0;
		seen = 2'bxx;
		while (rdy !== 1'b1 && k < 500) begin
			tick;
			k++;
		end
		req_cmd = c;
		fcount = n;
		req = 1'b1;
		tick;
		req = 1'b0;
		while (done !== 1'b1 && !(err_h === 1'b1 && rdy === 1'b1) && k < 2000) begin
			if (act === 1'b1) seen = acmd;
			tick;
			k++;
		end
		chk(seen, c);
		chk(k < 2000, 1'b1);
	endtask
	task automatic pulse2(input logic [1:0] c);
		lnk2.user_command_code = c;
		lnk2.cmd_valid = 1'b1;
		tick;
		lnk2.cmd_valid = 1'b0;
	endtask
	task automatic wait2;
		int k;
		k = 0;
		while (lnk2.user_status_word[0] !== 1'b0 && k < 200) begin
			tick;
			k++;
		end
		chk(k < 200, 1'b1);
	endtask
	task automatic t_refuse;
		pulse2(fsc_pkg::CMD_WRITE);
		wait2;
		chk(act2, 1'b0);
		pulse2(fsc_pkg::CMD_FORMAT);
		repeat (3) tick;
		pulse2(fsc_pkg::CMD_SHUTDOWN);
		wait2;
		chk(lnk2.inactive, 1'b0);
		pulse2(fsc_pkg::CMD_SHUTDOWN);
		wait2;
		chk(lnk2.inactive, 1'b1);
		pulse2(fsc_pkg::CMD_FORMAT);
		chk(lnk2.user_status_word, 3'h0);
	endtask
	task automatic t_format;
		fsize = 3'h2;
		run(fsc_pkg::CMD_FORMAT, 27'h0);
		chk(lnk.max_file_capacity, fsc_pkg::DEF_FILE_CAP >> 2);
		chk(lnk.disk_file_total, 27'h0);
		chk(lnk.disk_file_size, 3'h2);
		chk(elapsed > 32'(fsc_pkg::FORMAT_CYCLES) && elapsed < 32'(fsc_pkg::FORMAT_CYCLES + 8), 1'b1);
	endtask
	task automatic t_transfer;
		logic [31:0] ts;
		run(fsc_pkg::CMD_WRITE, 27'h2);
		chk({lnk.running_count_high, lnk.running_count_low}, 57'h2000);
		chk(bytes, 57'h2000);
		chk(lnk.disk_file_total, 27'h2);
		ts = lnk.creation_timestamp;
		mis_on = 1'b1;
		run(fsc_pkg::CMD_READ, 27'h1);
		mis_on = 1'b0;
		chk(lnk.user_status_word, 3'h4);
		chk({lnk.running_count_high, lnk.running_count_low}, 57'h1000);
		chk({err_h, verr_h}, 2'h1);
		chk(lnk.creation_timestamp, ts);
	endtask
	task automatic t_fault;
		err_on = 1'b1;
		run(fsc_pkg::CMD_WRITE, 27'h1);
		err_on = 1'b0;
		chk(lnk.start_file_number, 27'h2);
		chk(lnk.user_status_word[1:0], 2'h2);
		chk(err_h, 1'b1);
		run(fsc_pkg::CMD_SHUTDOWN, 27'h0);
		chk(lnk.inactive, 1'b1);
	endtask
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		req = 1'b0;
		req_cmd = 2'h0;
		fsize = 3'h0;
		fcount = 27'h0;
		mis_on = 1'b0;
		err_on = 1'b0;
		lnk2.cmd_valid = 1'b0;
		lnk2.user_command_code = 2'h0;
		lnk2.creation_timestamp = 32'h0;
		lnk2.requested_file_size = 3'h0;
		lnk2.start_file_number = 27'h0;
		lnk2.file_count_request = 27'h1;
		lnk2.test_pattern_select = 3'h0;
		n_fail = 0;
		n_checks = 0;
		repeat (16) tick;
		rst = 1'b0;
		tick;
		chk(lnk.user_status_word[0], 1'b1);
		t_refuse;
		chk(lnk.user_status_word, 3'h0);
		t_format;
		t_transfer;
		t_fault;
		end_sim;
	end
endmodule
